// ### rtl/hffg_decode.sv
// host bus cycle decoder
`timescale 1ns/10ps
`include "hffg_map.svh"
module hffg_decode (
  input  wire logic             dma_acknowledge_n_i,
  input  wire logic             cs_n_i,
  input  wire logic [2:0]       addr_i,
  input  wire logic             rd_n_i,
  input  wire logic             wr_n_i,
  output hffg_pkg::hffg_cyc_t   cyc_o,
  output logic                  is_read_o
);
  always_comb begin
    cyc_o     = hffg_pkg::HFFG_CYC_NONE;
    is_read_o = !rd_n_i && wr_n_i;
    if (rd_n_i == wr_n_i) begin
      cyc_o = hffg_pkg::HFFG_CYC_NONE;
    end else if (!dma_acknowledge_n_i) begin
      cyc_o = hffg_pkg::HFFG_CYC_DMA;
    end else if (!cs_n_i) begin
      case (addr_i)
        `HFFG_ADDR_DATA:   cyc_o = hffg_pkg::HFFG_CYC_DATA;
        `HFFG_ADDR_STREAM: cyc_o = hffg_pkg::HFFG_CYC_STREAM;
        `HFFG_ADDR_HOST_STATUS_REG:  cyc_o = rd_n_i ? hffg_pkg::HFFG_CYC_NONE : hffg_pkg::HFFG_CYC_HOST_STATUS_REG;
        `HFFG_ADDR_HOST_CONTROL_REG:   cyc_o = rd_n_i ? hffg_pkg::HFFG_CYC_HOST_CONTROL_REG_W : hffg_pkg::HFFG_CYC_HOST_CONTROL_REG_R;
        `HFFG_ADDR_IMM:    cyc_o = hffg_pkg::HFFG_CYC_IMM;
        default:           cyc_o = hffg_pkg::HFFG_CYC_NONE;
      endcase
    end
  end
endmodule : hffg_decode

// ### rtl/hffg_map.svh
// offsets, field positions, reset values and timing counts for the freeze gate
`ifndef HFFG_MAP_SVH
`define HFFG_MAP_SVH
`define HFFG_ADDR_DATA        3'h0
`define HFFG_ADDR_STREAM      3'h1
`define HFFG_ADDR_HOST_STATUS_REG       3'h2
`define HFFG_ADDR_HOST_CONTROL_REG        3'h3
`define HFFG_ADDR_IMM         3'h4
`define HFFG_SLAVE_CONTROL_REG_FREEZE_BIT 3
`define HFFG_MODE_IRQEN_BIT   4
`define HFFG_HOST_STATUS_REG_FREEZE_BIT 1
`define HFFG_SLAVE_STATUS_REG_FREEZE_BIT 5
`define HFFG_SLAVE_CONTROL_REG_RESET      8'h08
`define HFFG_REG_RESET        8'h00
`define HFFG_SLAVE_STATUS_REG_RESET      8'h20
`define HFFG_IRQ_RESP_OSC     86
`define HFFG_OSC_NS           63
`define HFFG_CLK_NS           100
`define HFFG_IRQ_RESP_CYC     ((`HFFG_IRQ_RESP_OSC * `HFFG_OSC_NS) / `HFFG_CLK_NS)
`endif

// ### rtl/hffg_pkg.sv
// types for the host fifo freeze gate
package hffg_pkg;
  typedef enum logic [2:0] {
    HFFG_NORMAL  = 3'b001,
    HFFG_SYNCING = 3'b010,
    HFFG_FROZEN  = 3'b100
  } hffg_state_t;
  typedef enum logic [3:0] {
    HFFG_CYC_NONE   = 4'h0,
    HFFG_CYC_HOST_STATUS_REG  = 4'h1,
    HFFG_CYC_HOST_CONTROL_REG_R = 4'h2,
    HFFG_CYC_HOST_CONTROL_REG_W = 4'h3,
    HFFG_CYC_DATA   = 4'h4,
    HFFG_CYC_STREAM = 4'h5,
    HFFG_CYC_IMM    = 4'h6,
    HFFG_CYC_DMA    = 4'h7
  } hffg_cyc_t;
endpackage : hffg_pkg

// ### rtl/hffg_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module hffg_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic q_reg;
  // s1 feeds only s2; a level counts once s2 and s3 agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
      q_reg  <= RESET_VAL;
    end else if (ce_i) begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        q_reg <= s3_reg;
      end
    end
  end
  assign q_o = q_reg;
endmodule : hffg_sync3

// ### rtl/hffg_top.sv
// freeze-mode gate between host slave bus and internal fifo logic
// Operation
// - host status read stays served while frozen
// - host control read stays served while frozen
// - host control write works normally, ignored while frozen
// - data reads and writes at address 000 blocked while frozen
// - data stream command transfers at address 001 blocked while frozen
// - immediate command transfers at address 100 blocked while frozen
// - acknowledged dma cycles blocked while frozen
// - freeze status flag reads 1 normal, 0 frozen; gates write permission
// - four fifo pointers writable by cpu only while frozen
// - channel boundary pointer writable by cpu only while frozen
// - input and output thresholds writable by cpu only while frozen
// - status writes and host control access by cpu only while frozen
// - immediate command to cpu writable only frozen; to host always
// - leaving freeze clears the host status freeze indication
// - freeze handshake by immediate commands, drain, freeze, reconfigure, release
// - cpu immediate command interrupt answered within 86 oscillator periods
// - freeze entered on freeze request bit, after host access completes
// - entering freeze raises host interrupt if mode bit 4 set
// - host status read clears interrupt and freeze indications
// - internal dma held disabled throughout freeze
`timescale 1ns/10ps
`include "hffg_map.svh"
module hffg_top #(
  parameter int RESP_CYC = `HFFG_IRQ_RESP_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic       dma_acknowledge_n_i,
  input  wire logic       cs_n_i,
  input  wire logic       host_addr_bit2_i,
  input  wire logic       host_addr_bit1_i,
  input  wire logic       host_addr_bit0_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic [7:0] host_data_i,
  input  wire logic [7:0] slave_control_wr_i,
  input  wire logic       slave_control_we_i,
  input  wire logic [7:0] mode_reg_i,
  input  wire logic       cpu_slave_status_reg_we_i,
  input  wire logic       cpu_host_status_reg_we_i,
  input  wire logic       cpu_host_control_reg_we_i,
  input  wire logic       cpu_ptr_we_i,
  input  wire logic       cpu_cbp_we_i,
  input  wire logic       cpu_thr_we_i,
  input  wire logic       cpu_immediate_command_to_cpu_we_i,
  input  wire logic       cpu_imout_we_i,
  input  wire logic [7:0] cpu_wdata_i,
  input  wire logic       cpu_imm_irq_i,
  output logic [7:0]      slave_control_reg_o,
  output logic [7:0]      host_status_reg_o,
  output logic [7:0]      slave_status_reg_o,
  output logic [7:0]      host_control_reg_o,
  output logic [7:0]      host_rdata_o,
  output logic            freeze_status_flag_o,
  output logic            host_interrupt_request_o,
  output logic            host_rd_grant_o,
  output logic            host_wr_grant_o,
  output logic            fifo_access_o,
  output logic            stream_access_o,
  output logic            imm_access_o,
  output logic            dma_access_o,
  output logic            internal_dma_enable_o,
  output logic            ptr_we_o,
  output logic            cbp_we_o,
  output logic            thr_we_o,
  output logic            immediate_command_to_cpu_we_o,
  output logic            imout_we_o,
  output logic            cpu_host_control_reg_rd_en_o,
  output logic            cpu_irq_take_o
);
  logic                dma_acknowledge_n_s;
  logic                cs_s;
  logic                a2_s;
  logic                a1_s;
  logic                a0_s;
  logic                rd_s;
  logic                wr_s;
  hffg_pkg::hffg_cyc_t cyc;
  logic                is_read;
  logic                strobe_busy;
  logic                host_status_reg_rd_prev_reg;
  logic                host_status_reg_rd_start;
  hffg_pkg::hffg_state_t state_reg;
  hffg_pkg::hffg_state_t state_next;
  logic                frozen;
  logic                allow;
  logic [7:0]          slave_control_reg_reg;
  logic [7:0]          host_status_reg_reg;
  logic [7:0]          slave_status_reg_reg;
  logic [7:0]          host_control_reg_reg;
  logic [7:0]          rdata_reg;
  logic [7:0]          hdata1_reg;
  logic [7:0]          hdata2_reg;
  logic [7:0]          hdata3_reg;
  logic                irq_reg;
  logic [15:0]         resp_cnt_reg;
  logic                resp_busy_reg;
  logic                take_reg;

  // host pins come from another clock; three stages each, strobes and selects reset idle-high, address bits low
  hffg_sync3 #(.RESET_VAL(1'b1)) u_s_dma_acknowledge_n (
    .clk_i  (clk_i),
    .rst_n_i(rst_n_i),
    .ce_i   (ce_i),
    .d_i    (dma_acknowledge_n_i),
    .q_o    (dma_acknowledge_n_s)
  );
  hffg_sync3 #(.RESET_VAL(1'b1)) u_s_cs (
    .clk_i  (clk_i),
    .rst_n_i(rst_n_i),
    .ce_i   (ce_i),
    .d_i    (cs_n_i),
    .q_o    (cs_s)
  );
  hffg_sync3 #(.RESET_VAL(1'b0)) u_s_a2 (
    .clk_i  (clk_i),
    .rst_n_i(rst_n_i),
    .ce_i   (ce_i),
    .d_i    (host_addr_bit2_i),
    .q_o    (a2_s)
  );
  hffg_sync3 #(.RESET_VAL(1'b0)) u_s_a1 (
    .clk_i  (clk_i),
    .rst_n_i(rst_n_i),
    .ce_i   (ce_i),
    .d_i    (host_addr_bit1_i),
    .q_o    (a1_s)
  );
  hffg_sync3 #(.RESET_VAL(1'b0)) u_s_a0 (
    .clk_i  (clk_i),
    .rst_n_i(rst_n_i),
    .ce_i   (ce_i),
    .d_i    (host_addr_bit0_i),
    .q_o    (a0_s)
  );
  hffg_sync3 #(.RESET_VAL(1'b1)) u_s_rd (
    .clk_i  (clk_i),
    .rst_n_i(rst_n_i),
    .ce_i   (ce_i),
    .d_i    (rd_n_i),
    .q_o    (rd_s)
  );
  hffg_sync3 #(.RESET_VAL(1'b1)) u_s_wr (
    .clk_i  (clk_i),
    .rst_n_i(rst_n_i),
    .ce_i   (ce_i),
    .d_i    (wr_n_i),
    .q_o    (wr_s)
  );

  // host data lags three edges so it lines up with the synchronised write strobe;
  // the pins may already change while the late strobe still decodes as a write
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hdata1_reg <= `HFFG_REG_RESET;
      hdata2_reg <= `HFFG_REG_RESET;
      hdata3_reg <= `HFFG_REG_RESET;
    end else if (ce_i) begin
      hdata1_reg <= host_data_i;
      hdata2_reg <= hdata1_reg;
      hdata3_reg <= hdata2_reg;
    end
  end

  hffg_decode u_dec (
    .dma_acknowledge_n_i(dma_acknowledge_n_s),
    .cs_n_i             (cs_s),
    .addr_i             ({a2_s, a1_s, a0_s}),
    .rd_n_i             (rd_s),
    .wr_n_i             (wr_s),
    .cyc_o              (cyc),
    .is_read_o          (is_read)
  );

  assign strobe_busy = !(rd_s && wr_s);
  assign frozen      = (state_reg == hffg_pkg::HFFG_FROZEN);

  // freeze request bit active low; entry waits for the host strobe to finish so
  // a cycle already granted is never cut short
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      hffg_pkg::HFFG_NORMAL: begin
        if (!slave_control_reg_reg[`HFFG_SLAVE_CONTROL_REG_FREEZE_BIT]) begin
          state_next = hffg_pkg::HFFG_SYNCING;
        end
      end
      hffg_pkg::HFFG_SYNCING: begin
        if (slave_control_reg_reg[`HFFG_SLAVE_CONTROL_REG_FREEZE_BIT]) begin
          state_next = hffg_pkg::HFFG_NORMAL;
        end else if (!strobe_busy) begin
          state_next = hffg_pkg::HFFG_FROZEN;
        end
      end
      hffg_pkg::HFFG_FROZEN: begin
        if (slave_control_reg_reg[`HFFG_SLAVE_CONTROL_REG_FREEZE_BIT]) begin
          state_next = hffg_pkg::HFFG_NORMAL;
        end
      end
      default: state_next = hffg_pkg::HFFG_NORMAL;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= hffg_pkg::HFFG_NORMAL;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slave_control_reg_reg <= `HFFG_SLAVE_CONTROL_REG_RESET;
    end else if (ce_i && slave_control_we_i) begin
      slave_control_reg_reg <= slave_control_wr_i;
    end
  end

  // which host cycles still pass while frozen
  always_comb begin
    case (cyc)
      hffg_pkg::HFFG_CYC_HOST_STATUS_REG:  allow = 1'b1;
      hffg_pkg::HFFG_CYC_HOST_CONTROL_REG_R: allow = 1'b1;
      hffg_pkg::HFFG_CYC_HOST_CONTROL_REG_W: allow = !frozen;
      hffg_pkg::HFFG_CYC_DATA:   allow = !frozen;
      hffg_pkg::HFFG_CYC_STREAM: allow = !frozen;
      hffg_pkg::HFFG_CYC_IMM:    allow = !frozen;
      hffg_pkg::HFFG_CYC_DMA:    allow = !frozen;
      default:                   allow = 1'b0;
    endcase
  end

  assign host_rd_grant_o = allow && is_read;
  assign host_wr_grant_o = allow && !is_read;
  assign fifo_access_o   = allow && (cyc == hffg_pkg::HFFG_CYC_DATA);
  assign stream_access_o = allow && (cyc == hffg_pkg::HFFG_CYC_STREAM);
  assign imm_access_o    = allow && (cyc == hffg_pkg::HFFG_CYC_IMM);
  assign dma_access_o    = allow && (cyc == hffg_pkg::HFFG_CYC_DMA);

  // one pulse per host status read, so a long strobe clears only once
  assign host_status_reg_rd_start = (cyc == hffg_pkg::HFFG_CYC_HOST_STATUS_REG) && !host_status_reg_rd_prev_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_status_reg_rd_prev_reg <= 1'b0;
    end else if (ce_i) begin
      host_status_reg_rd_prev_reg <= (cyc == hffg_pkg::HFFG_CYC_HOST_STATUS_REG);
    end
  end

  // freeze entry sets the indications; set wins over a same-cycle clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_status_reg_reg <= `HFFG_REG_RESET;
    end else if (ce_i) begin
      if (state_next == hffg_pkg::HFFG_FROZEN && !frozen) begin
        host_status_reg_reg[`HFFG_HOST_STATUS_REG_FREEZE_BIT] <= 1'b1;
      end else if (frozen && state_next == hffg_pkg::HFFG_NORMAL) begin
        host_status_reg_reg[`HFFG_HOST_STATUS_REG_FREEZE_BIT] <= 1'b0;
      end else if (frozen && cpu_host_status_reg_we_i) begin
        host_status_reg_reg <= cpu_wdata_i;
      end else if (host_status_reg_rd_start) begin
        host_status_reg_reg[`HFFG_HOST_STATUS_REG_FREEZE_BIT] <= 1'b0;
      end
    end
  end

  // slave_status_reg freeze bit: 1 normal, 0 frozen
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slave_status_reg_reg <= `HFFG_SLAVE_STATUS_REG_RESET;
    end else if (ce_i) begin
      if (frozen && cpu_slave_status_reg_we_i) begin
        slave_status_reg_reg <= cpu_wdata_i;
      end else begin
        slave_status_reg_reg[`HFFG_SLAVE_STATUS_REG_FREEZE_BIT] <= !(state_next == hffg_pkg::HFFG_FROZEN);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_control_reg_reg <= `HFFG_REG_RESET;
    end else if (ce_i) begin
      if (frozen && cpu_host_control_reg_we_i) begin
        host_control_reg_reg <= cpu_wdata_i;
      end else if (cyc == hffg_pkg::HFFG_CYC_HOST_CONTROL_REG_W && allow) begin
        host_control_reg_reg <= hdata3_reg;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_reg <= 1'b0;
    end else if (ce_i) begin
      if (state_next == hffg_pkg::HFFG_FROZEN && !frozen && mode_reg_i[`HFFG_MODE_IRQEN_BIT]) begin
        irq_reg <= 1'b1;
      end else if (host_status_reg_rd_start) begin
        irq_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= `HFFG_REG_RESET;
    end else if (ce_i) begin
      if (host_status_reg_rd_start) begin
        rdata_reg <= host_status_reg_reg;
      end else if (cyc == hffg_pkg::HFFG_CYC_HOST_CONTROL_REG_R) begin
        rdata_reg <= host_control_reg_reg;
      end
    end
  end

  // immediate command response budget; timer stands in for cpu latency
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      resp_cnt_reg  <= 16'h0000;
      resp_busy_reg <= 1'b0;
      take_reg      <= 1'b0;
    end else if (ce_i) begin
      take_reg <= 1'b0;
      if (resp_busy_reg) begin
        if (resp_cnt_reg >= 16'(RESP_CYC - 1)) begin
          take_reg      <= 1'b1;
          resp_busy_reg <= 1'b0;
        end else begin
          resp_cnt_reg <= resp_cnt_reg + 16'h0001;
        end
      end else if (cpu_imm_irq_i) begin
        resp_busy_reg <= 1'b1;
        resp_cnt_reg  <= 16'h0000;
      end
    end
  end

  assign freeze_status_flag_o     = slave_status_reg_reg[`HFFG_SLAVE_STATUS_REG_FREEZE_BIT];
  assign internal_dma_enable_o    = !frozen;
  assign ptr_we_o                 = frozen && cpu_ptr_we_i;
  assign cbp_we_o                 = frozen && cpu_cbp_we_i;
  assign thr_we_o                 = frozen && cpu_thr_we_i;
  assign immediate_command_to_cpu_we_o                = frozen && cpu_immediate_command_to_cpu_we_i;
  assign imout_we_o               = cpu_imout_we_i;
  assign cpu_host_control_reg_rd_en_o         = frozen;
  assign slave_control_reg_o      = slave_control_reg_reg;
  assign host_status_reg_o        = host_status_reg_reg;
  assign slave_status_reg_o       = slave_status_reg_reg;
  assign host_control_reg_o       = host_control_reg_reg;
  assign host_rdata_o             = rdata_reg;
  assign host_interrupt_request_o = irq_reg;
  assign cpu_irq_take_o           = take_reg;
endmodule : hffg_top

// ### tb/hffg_checker.sv
// port assertions for the freeze gate
`timescale 1ns/10ps
module hffg_checker (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       slave_control_we_i,
  input  wire logic [7:0] slave_control_wr_i,
  input  wire logic [7:0] mode_reg_i,
  input  wire logic       cpu_ptr_we_i,
  input  wire logic       cpu_imout_we_i,
  input  wire logic [7:0] host_status_reg_o,
  input  wire logic       freeze_status_flag_o,
  input  wire logic       host_interrupt_request_o,
  input  wire logic       host_wr_grant_o,
  input  wire logic       fifo_access_o,
  input  wire logic       stream_access_o,
  input  wire logic       imm_access_o,
  input  wire logic       dma_access_o,
  input  wire logic       internal_dma_enable_o,
  input  wire logic       ptr_we_o,
  input  wire logic       imout_we_o,
  input  wire logic       cpu_host_control_reg_rd_en_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_frozen_no_fifo: assert property (!internal_dma_enable_o |-> !fifo_access_o)
    else $error("fifo access while frozen");
  a_frozen_no_path: assert property (!internal_dma_enable_o
    |-> !(stream_access_o || imm_access_o || dma_access_o))
    else $error("stream, command or dma path open while frozen");
  a_frozen_no_wr: assert property (!internal_dma_enable_o |-> !host_wr_grant_o)
    else $error("host write granted while frozen");
  a_ptr_gate: assert property (cpu_ptr_we_i |-> ptr_we_o == !internal_dma_enable_o)
    else $error("pointer write gate wrong");
  a_host_control_reg_rd_gate: assert property (cpu_host_control_reg_rd_en_o == !internal_dma_enable_o)
    else $error("host control read enable wrong");
  a_imout_pass: assert property (imout_we_o == cpu_imout_we_i)
    else $error("outgoing command write not passed");
  // bound assumes no host strobe is pending when freeze is asked for
  a_enter_bound: assert property (slave_control_we_i && !slave_control_wr_i[3]
    && freeze_status_flag_o |-> ##[1:20] !freeze_status_flag_o)
    else $error("freeze not entered");
  a_exit_clears: assert property (slave_control_we_i && slave_control_wr_i[3]
    && !freeze_status_flag_o |=> ##[0:2] freeze_status_flag_o && !host_status_reg_o[1])
    else $error("freeze exit incomplete");
  a_irq_on_entry: assert property ($fell(freeze_status_flag_o) && mode_reg_i[4]
    |-> ##[0:1] host_interrupt_request_o)
    else $error("no host interrupt on freeze");
  c_enter: cover property ($fell(freeze_status_flag_o));
  c_exit: cover property ($rose(freeze_status_flag_o));
  c_wr: cover property (host_wr_grant_o);
endmodule : hffg_checker

bind hffg_top hffg_checker u_chk (.clk_i, .rst_n_i, .slave_control_we_i, .slave_control_wr_i,
  .mode_reg_i, .cpu_ptr_we_i, .cpu_imout_we_i, .host_status_reg_o, .freeze_status_flag_o,
  .host_interrupt_request_o, .host_wr_grant_o, .fifo_access_o, .stream_access_o,
  .imm_access_o, .dma_access_o, .internal_dma_enable_o,
  .ptr_we_o, .imout_we_o, .cpu_host_control_reg_rd_en_o);

// ### tb/hffg_host_model.sv
// external host cpu model on the slave bus pins
`timescale 1ns/10ps
module hffg_host_model (
  input  wire logic       clk_i,
  input  wire logic       rd_grant_i,
  input  wire logic       wr_grant_i,
  output logic            dma_acknowledge_n_o,
  output logic            cs_n_o,
  output logic [2:0]      addr_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic [7:0]      data_o,
  output logic            done_o,
  output logic            granted_o
);
  initial begin
    {dma_acknowledge_n_o, cs_n_o, addr_o, rd_n_o, wr_n_o} = 7'h7f;
    data_o = 8'h5a;
    done_o = 1'b0;
    granted_o = 1'b0;
  end
  task automatic cycle(input logic [6:0] pins, input logic [7:0] d, input int hold);
    logic g;
    g = 1'b0;
    @(posedge clk_i) #1;
    {dma_acknowledge_n_o, cs_n_o, addr_o, rd_n_o, wr_n_o} = pins;
    data_o = d;
    repeat (hold) begin
      @(negedge clk_i);
      g = g | rd_grant_i | wr_grant_i;
    end
    @(posedge clk_i) #1;
    {dma_acknowledge_n_o, cs_n_o, rd_n_o, wr_n_o} = 4'hf;
    // strobes drop first; released lines keep changing so nothing stale is read
    repeat (6) begin
      @(posedge clk_i) #1;
      addr_o = ~addr_o;
      data_o = ~data_o;
    end
    granted_o = g;
    done_o = 1'b1;
    @(posedge clk_i) #1;
    done_o = 1'b0;
  endtask : cycle
endmodule : hffg_host_model

// ### tb/tb_top.sv
// self-checking bench for the freeze gate
`timescale 1ns/10ps
module tb_top;
  localparam int RESP = 4;
  logic        clk_i, rst_n_i, ce_i, dma_acknowledge_n_i, cs_n_i, rd_n_i, wr_n_i;
  logic [2:0]  ha;
  logic [7:0]  host_data_i, slave_control_wr_i, mode_reg_i, cpu_wdata_i, hc, ss, host_rdata_o;
  logic        slave_control_we_i, cpu_slave_status_reg_we_i, cpu_host_status_reg_we_i, cpu_host_control_reg_we_i;
  logic        cpu_ptr_we_i, cpu_cbp_we_i, cpu_thr_we_i, cpu_immediate_command_to_cpu_we_i, cpu_imout_we_i;
  logic        cpu_imm_irq_i, freeze_status_flag_o, host_interrupt_request_o;
  logic [7:0]  slave_control_reg_o, host_status_reg_o, slave_status_reg_o, host_control_reg_o;
  logic        host_rd_grant_o, host_wr_grant_o, fifo_access_o, internal_dma_enable_o;
  logic        ptr_we_o, cbp_we_o, thr_we_o, immediate_command_to_cpu_we_o, imout_we_o, cpu_host_control_reg_rd_en_o;
  logic        cpu_irq_take_o, h_done, h_granted;
  int          n_mismatch, n_compared, cyc, n;
  logic        exp_q[$];
  logic [31:0] seed;
  logic [6:0]  tbl [11];
  hffg_top #(.RESP_CYC(RESP)) uut (
    .clk_i, .rst_n_i, .ce_i, .dma_acknowledge_n_i, .cs_n_i, .host_addr_bit2_i(ha[2]),
    .host_addr_bit1_i(ha[1]), .host_addr_bit0_i(ha[0]), .rd_n_i, .wr_n_i, .host_data_i,
    .slave_control_wr_i, .slave_control_we_i, .mode_reg_i, .cpu_slave_status_reg_we_i, .cpu_host_status_reg_we_i,
    .cpu_host_control_reg_we_i, .cpu_ptr_we_i, .cpu_cbp_we_i, .cpu_thr_we_i, .cpu_immediate_command_to_cpu_we_i,
    .cpu_imout_we_i, .cpu_wdata_i, .cpu_imm_irq_i, .slave_control_reg_o, .host_status_reg_o,
    .slave_status_reg_o, .host_control_reg_o, .host_rdata_o, .freeze_status_flag_o,
    .host_interrupt_request_o, .host_rd_grant_o, .host_wr_grant_o, .fifo_access_o,
    .stream_access_o(), .imm_access_o(), .dma_access_o(), .internal_dma_enable_o, .ptr_we_o,
    .cbp_we_o, .thr_we_o, .immediate_command_to_cpu_we_o, .imout_we_o, .cpu_host_control_reg_rd_en_o, .cpu_irq_take_o);
  hffg_host_model host (.clk_i, .rd_grant_i(host_rd_grant_o), .wr_grant_i(host_wr_grant_o),
    .dma_acknowledge_n_o(dma_acknowledge_n_i), .cs_n_o(cs_n_i), .addr_o(ha), .rd_n_o(rd_n_i),
    .wr_n_o(wr_n_i), .data_o(host_data_i), .done_o(h_done), .granted_o(h_granted));
  always #50 clk_i = ~clk_i;
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  function automatic logic [7:0] st();
    return {freeze_status_flag_o, host_interrupt_request_o, host_status_reg_o[1],
            internal_dma_enable_o, cpu_host_control_reg_rd_en_o, 3'h0};
  endfunction : st
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      close_out();
    end
    if (h_done) begin
      n_compared++;
      if (exp_q.size() == 0 || h_granted !== exp_q.pop_front()) begin
        n_mismatch++;
        $display("Error at %0t: host grant differs", $time);
      end
    end
  end
  // dma rows carry random chip select and address, which must not matter
  task automatic run_tbl(input logic frozen);
    logic [6:0] p;
    for (int i = 0; i < 11; i++) begin
      seed = nxt(seed);
      p = (i < 9) ? tbl[i] : {1'b0, seed[3:0], tbl[i][1:0]};
      exp_q.push_back(!frozen || i < 2);
      host.cycle(p, seed[15:8], seed[0] ? 10 : 6);
      if (i == 2 && !frozen) hc = seed[15:8];
      if (i == 2) chk(host_control_reg_o, hc);
      if (i == 0) chk(host_rdata_o, {6'h00, frozen, 1'b0});
      if (i == 1) chk(host_rdata_o, hc);
    end
  endtask : run_tbl
  task automatic cpu_try(input logic frozen);
    seed = nxt(seed);
    cpu_wdata_i = (seed[7:0] & 8'hdf) | 8'h02;
    {cpu_slave_status_reg_we_i, cpu_host_status_reg_we_i, cpu_host_control_reg_we_i, cpu_ptr_we_i, cpu_cbp_we_i} = 5'h1f;
    {cpu_thr_we_i, cpu_immediate_command_to_cpu_we_i, cpu_imout_we_i} = 3'h7;
    @(negedge clk_i);
    chk({ptr_we_o, cbp_we_o, thr_we_o, immediate_command_to_cpu_we_o, imout_we_o, 3'h0}, {{4{frozen}}, 4'h8});
    @(posedge clk_i) #1;
    {cpu_slave_status_reg_we_i, cpu_host_status_reg_we_i, cpu_host_control_reg_we_i, cpu_ptr_we_i, cpu_cbp_we_i} = 5'h00;
    {cpu_thr_we_i, cpu_immediate_command_to_cpu_we_i, cpu_imout_we_i} = 3'h0;
    if (frozen) hc = cpu_wdata_i;
    if (frozen) ss = cpu_wdata_i;
    @(negedge clk_i);
    chk(host_control_reg_o, hc);
    if (frozen) chk(host_status_reg_o, cpu_wdata_i);
    chk(slave_status_reg_o, ss | {2'h0, !frozen, 5'h00});
    @(posedge clk_i) #1;
  endtask : cpu_try
  task automatic slave_control_reg(input logic [7:0] v);
    slave_control_wr_i = v;
    slave_control_we_i = 1'b1;
    @(posedge clk_i) #1;
    slave_control_we_i = 1'b0;
    for (int i = 0; i < 20 && freeze_status_flag_o !== v[3]; i++) @(posedge clk_i) #1;
  endtask : slave_control_reg
  initial begin
    {clk_i, rst_n_i, slave_control_we_i, cpu_slave_status_reg_we_i, cpu_imm_irq_i} = 5'h0;
    {cpu_host_status_reg_we_i, cpu_host_control_reg_we_i, cpu_ptr_we_i, cpu_cbp_we_i} = 4'h0;
    {cpu_thr_we_i, cpu_immediate_command_to_cpu_we_i, cpu_imout_we_i} = 3'h0;
    ce_i = 1'b1;
    slave_control_wr_i = 8'h08;
    mode_reg_i = 8'h10;
    cpu_wdata_i = 8'h00;
    seed = 32'h7f64;
    hc = 8'h00;
    ss = 8'h20;
    tbl = '{7'b1001001, 7'b1001101, 7'b1001110, 7'b1000001, 7'b1000010, 7'b1000101,
            7'b1000110, 7'b1010001, 7'b1010010, 7'b0000001, 7'b0000010};
    repeat (5) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    chk(slave_control_reg_o, 8'h08);
    chk(slave_status_reg_o, 8'h20);
    chk(st(), 8'h90);
    run_tbl(1'b0);
    cpu_try(1'b0);
    chk(st(), 8'h90);
    cpu_imm_irq_i = 1'b1;
    @(posedge clk_i) #1;
    cpu_imm_irq_i = 1'b0;
    n = 0;
    while (cpu_irq_take_o !== 1'b1 && n < 100) begin
      @(posedge clk_i) #1;
      n++;
    end
    chk(8'(n > 0 && n <= RESP), 8'h01);
    slave_control_reg(8'h00);
    chk(st(), 8'h68);
    run_tbl(1'b1);
    chk(st(), 8'h08);
    cpu_try(1'b1);
    slave_control_reg(8'h08);
    chk(st(), 8'h90);
    cpu_try(1'b0);
    mode_reg_i = 8'h00;
    slave_control_reg(8'h00);
    chk(st(), 8'h28);
    slave_control_reg(8'h08);
    chk(st(), 8'h90);
    close_out();
  end
endmodule : tb_top
